// ### inc/ecl_pkg.sv
// package: configuration image layout, field positions and reset values
package ecl_pkg;

	// ==========================================================
	// image byte addresses
	localparam logic [8:0] ADR_SIG      = 9'h000;
	localparam logic [8:0] ADR_MAC_LO   = 9'h001;
	localparam logic [8:0] ADR_MAC_HI   = 9'h006;
	localparam logic [8:0] ADR_FS_POLL  = 9'h007;
	localparam logic [8:0] ADR_HS_POLL  = 9'h008;
	localparam logic [8:0] ADR_FLAGS    = 9'h009;
	localparam logic [8:0] ADR_LANG_LO  = 9'h00a;
	localparam logic [8:0] ADR_LANG_HI  = 9'h00b;
	localparam logic [8:0] ADR_STR_LO   = 9'h00c;
	localparam logic [8:0] ADR_STR_HI   = 9'h015;
	localparam logic [8:0] ADR_DSC_LO   = 9'h016;
	localparam logic [8:0] ADR_DSC_HI   = 9'h01d;
	localparam logic [8:0] ADR_WAKE_LO  = 9'h01e;
	localparam logic [8:0] ADR_WAKE_HI  = 9'h01f;
	localparam logic [8:0] ADR_PME      = 9'h020;

	localparam logic [7:0] IMAGE_SIGNATURE = 8'ha5;

	// ==========================================================
	// configuration flags byte fields
	localparam int FLG_POWER_BIT  = 0;
	localparam int FLG_LED_BIT    = 1;
	localparam int FLG_WAKEUP_BIT = 2;
	localparam int FLG_BOOST_LSB  = 4;

	// ==========================================================
	// descriptor layout and fixed overrides
	localparam int         DSC_COUNT     = 4;
	localparam int         STR_COUNT     = 5;
	localparam logic [4:0] DSC_MAX_BYTES = 5'd18;
	localparam logic [4:0] DSC_IDX_LEN   = 5'd0;
	localparam logic [4:0] DSC_IDX_TYPE  = 5'd1;
	localparam logic [4:0] CFG_IDX_ATTR  = 5'd7;
	localparam int         ATTR_SELF_BIT = 6;
	localparam int         ATTR_WAKE_BIT = 5;
	localparam logic [7:0] DEV_DSC_LEN   = 8'h12;
	localparam logic [7:0] DEV_DSC_TYPE  = 8'h01;
	localparam logic [7:0] CFG_DSC_TYPE  = 8'h02;

	// descriptor slots: hs device, hs config, fs device, fs config
	localparam logic [2:0] SLOT_HS_DEV = 3'd0;
	localparam logic [2:0] SLOT_HS_CFG = 3'd1;
	localparam logic [2:0] SLOT_FS_CFG = 3'd3;

	// ==========================================================
	// reset values used while no valid image is present
	localparam logic [47:0] RST_MAC       = 48'h0;
	localparam logic [7:0]  RST_FS_POLL   = 8'h01;
	localparam logic [7:0]  RST_HS_POLL   = 8'h04;
	localparam logic [15:0] RST_LANG_ID   = 16'h0409;
	localparam logic [10:0] RST_GPIO_WAKE = 11'h000;
	localparam logic [7:0]  RST_PME_FLAGS = 8'h00;
	localparam logic [1:0]  RST_BOOST     = 2'h0;

	typedef enum logic [2:0] {
		ST_BOOT,
		ST_HDR_REQ,
		ST_HDR_WAIT,
		ST_DSC_NEXT,
		ST_DSC_REQ,
		ST_DSC_WAIT,
		ST_DONE
	} ecl_state_t;

endpackage

// ### inc/ecl_fetch_if.sv
// interface: one-byte read request between loader and fetcher
interface ecl_fetch_if;
	logic       req;
	logic [8:0] addr;
	logic       done;
	logic [7:0] data;

	modport loader (
		output req,
		output addr,
		input  done,
		input  data
	);

	modport fetcher (
		input  req,
		input  addr,
		output done,
		output data
	);
endinterface

// ### rtl/ecl_byte_fetch.sv
// module: single-byte read handshake towards the eeprom serial engine
module ecl_byte_fetch (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       eeprom_size_strap,
	output logic            ee_rd_req,
	output logic [8:0]      ee_rd_addr,
	input  wire logic       ee_rd_valid,
	input  wire logic [7:0] ee_rd_data,
	ecl_fetch_if.fetcher    f
);

	logic size_q;
	logic strap_taken_q;

	// ==========================================================
	// size strap, caught once after reset release
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			size_q        <= 1'b0;
			strap_taken_q <= 1'b0;
		end else if (!strap_taken_q) begin
			size_q        <= eeprom_size_strap;
			strap_taken_q <= 1'b1;
		end
	end

	// ==========================================================
	// request held until the serial engine answers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ee_rd_req  <= 1'b0;
			ee_rd_addr <= 9'h000;
		end else if (f.req) begin
			ee_rd_req  <= 1'b1;
			// [R22] seven or nine address bits
			ee_rd_addr <= size_q ? f.addr : {2'b00, f.addr[6:0]};
		end else if (ee_rd_valid) begin
			ee_rd_req  <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			f.done <= 1'b0;
			f.data <= 8'h00;
		end else begin
			f.done <= ee_rd_req && ee_rd_valid;
			if (ee_rd_req && ee_rd_valid)
				f.data <= ee_rd_data;
		end
	end

endmodule

// ### rtl/ecl_image_loader.sv
// module: power-up configuration image loader
// Operation
// [R1] image valid only with signature at byte 0; address bytes 1-6 low first
// [R2] full-speed poll interval from 07h, high-speed from 08h
// [R3] language id low byte 0Ah, high byte 0Bh
// [R4] five string length/word-offset pairs at 0Ch-15h, length first
// [R5] high-speed device and config descriptor pairs at 16h-19h
// [R6] full-speed device and config descriptor pairs at 1Ah-1Dh
// [R7] enhanced only: eleven-bit gpio wake enables from 1Eh/1Fh
// [R8] enhanced only: gpio wake-signalling flags byte from 20h
// [R9] device descriptor type always reads as one
// [R10] device descriptor length always reads as eighteen
// [R11] configuration descriptor type always reads as two
// [R12] programmer must store bcdUSB 0200h, packet size 40h, one configuration
// [R13] bytes past 1Dh (base) or 20h (enhanced) are never read; the loader still reads descriptor bytes past them at their word offsets
// [R14] valid image flags byte overrides wakeup and power straps
// [R15] loaded configuration descriptor attributes override flags and straps
// [R16] flags bit 2 set advertises remote wakeup
// [R17] flags bit 0 clear is bus powered, set is self powered
// [R18] enhanced: flags bits 5:4 load phy output boost
// [R19] enhanced: flags bit 1 loads led function select
// [R20] offsets are word offsets; zero length means use hardware default
// [R21] load after reset; host transactions refused until load ends
// [R22] seven address bits for small part, nine for large part
module ecl_image_loader #(
	parameter bit ENHANCED = 1'b1
) (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              eeprom_size_strap,
	input  wire logic              remote_wakeup_strap,
	input  wire logic              power_source_strap,
	output logic                   ee_rd_req,
	output logic [8:0]             ee_rd_addr,
	input  wire logic              ee_rd_valid,
	input  wire logic [7:0]        ee_rd_data,
	output logic                   load_done,
	output logic                   usb_accept,
	output logic                   image_valid,
	output logic [47:0]            mac_addr,
	output logic [7:0]             fs_poll_interval,
	output logic [7:0]             hs_poll_interval,
	output logic [15:0]            usb_lang_id,
	output logic [4:0][7:0]        str_len,
	output logic [4:0][7:0]        str_word_off,
	output logic [3:0][7:0]        desc_len,
	output logic [3:0][7:0]        desc_word_off,
	output logic [3:0]             desc_present,
	output logic [10:0]            gpio_wake_enable_bits,
	output logic [7:0]             gpio_pme_flags,
	output logic [1:0]             phy_output_boost,
	output logic                   led_function_select,
	output logic                   remote_wakeup_en,
	output logic                   self_powered,
	input  wire logic [1:0]        desc_rd_sel,
	input  wire logic [4:0]        desc_rd_idx,
	output logic [7:0]             desc_rd_data
);

	// ==========================================================
	// helpers
	function automatic logic [6:0] mem_index(input logic [1:0] sel, input logic [4:0] idx);
		mem_index = 7'(sel) * 7'(ecl_pkg::DSC_MAX_BYTES) + 7'(idx);
	endfunction

	// fixed fields are patched on the way out so stored junk never leaks
	function automatic logic [7:0] desc_patch(input logic [1:0] sel, input logic [4:0] idx,
	                                          input logic [7:0] raw);
		if (idx >= ecl_pkg::DSC_MAX_BYTES)
			desc_patch = 8'h00;
		// [R10] device length forced
		else if (!sel[0] && idx == ecl_pkg::DSC_IDX_LEN)
			desc_patch = ecl_pkg::DEV_DSC_LEN;
		// [R9] device type forced
		else if (!sel[0] && idx == ecl_pkg::DSC_IDX_TYPE)
			desc_patch = ecl_pkg::DEV_DSC_TYPE;
		// [R11] config type forced
		else if (sel[0] && idx == ecl_pkg::DSC_IDX_TYPE)
			desc_patch = ecl_pkg::CFG_DSC_TYPE;
		else
			desc_patch = raw;
	endfunction

	// ==========================================================
	// fetcher
	ecl_fetch_if f ();

	ecl_byte_fetch u_fetch (
		.ref_clk           (ref_clk),
		.rst               (rst),
		.eeprom_size_strap (eeprom_size_strap),
		.ee_rd_req         (ee_rd_req),
		.ee_rd_addr        (ee_rd_addr),
		.ee_rd_valid       (ee_rd_valid),
		.ee_rd_data        (ee_rd_data),
		.f                 (f)
	);

	// ==========================================================
	// sequencer state
	ecl_pkg::ecl_state_t state_q;
	logic [8:0]          addr_q;
	logic [2:0]          slot_q;
	logic [4:0]          didx_q;
	logic [4:0]          dlast_q;
	logic [7:0]          flags_q;
	logic [7:0]          dmem [0:71];
	logic [8:0]          last_addr;
	logic [7:0]          slot_len;
	logic                sig_ok;

	// [R13] header stops at the variant's last byte
	assign last_addr = ENHANCED ? ecl_pkg::ADR_PME : ecl_pkg::ADR_DSC_HI;
	assign slot_len  = desc_len[slot_q[1:0]];
	assign sig_ok    = f.data == ecl_pkg::IMAGE_SIGNATURE;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			f.req <= 1'b0;
			f.addr <= 9'h000;
		end else begin
			f.req <= (state_q == ecl_pkg::ST_HDR_REQ) || (state_q == ecl_pkg::ST_DSC_REQ);
			f.addr <= addr_q;
		end
	end

	// ==========================================================
	// load sequence
	// [R21] runs once after reset release
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ecl_pkg::ST_BOOT;
			addr_q  <= 9'h000;
			slot_q  <= 3'd0;
			didx_q  <= 5'd0;
			dlast_q <= 5'd0;
		end else begin
			case (state_q)
				ecl_pkg::ST_BOOT: begin
					addr_q  <= ecl_pkg::ADR_SIG;
					state_q <= ecl_pkg::ST_HDR_REQ;
				end
				ecl_pkg::ST_HDR_REQ: begin
					state_q <= ecl_pkg::ST_HDR_WAIT;
				end
				ecl_pkg::ST_HDR_WAIT: begin
					if (f.done) begin
						// [R1] bad signature ends the load at once
						if (addr_q == ecl_pkg::ADR_SIG && !sig_ok) begin
							state_q <= ecl_pkg::ST_DONE;
						end else if (addr_q == last_addr) begin
							slot_q  <= 3'd0;
							state_q <= ecl_pkg::ST_DSC_NEXT;
						end else begin
							addr_q  <= addr_q + 9'd1;
							state_q <= ecl_pkg::ST_HDR_REQ;
						end
					end
				end
				ecl_pkg::ST_DSC_NEXT: begin
					if (slot_q == 3'(ecl_pkg::DSC_COUNT)) begin
						state_q <= ecl_pkg::ST_DONE;
					// [R20] zero length leaves the slot at its default
					end else if (slot_len == 8'h00) begin
						slot_q <= slot_q + 3'd1;
					end else begin
						// [R20] word offset to byte address
						addr_q  <= {desc_word_off[slot_q[1:0]], 1'b0};
						didx_q  <= 5'd0;
						dlast_q <= (slot_len > 8'(ecl_pkg::DSC_MAX_BYTES)) ?
						           ecl_pkg::DSC_MAX_BYTES - 5'd1 : slot_len[4:0] - 5'd1;
						state_q <= ecl_pkg::ST_DSC_REQ;
					end
				end
				ecl_pkg::ST_DSC_REQ: begin
					state_q <= ecl_pkg::ST_DSC_WAIT;
				end
				ecl_pkg::ST_DSC_WAIT: begin
					if (f.done) begin
						if (didx_q == dlast_q) begin
							slot_q  <= slot_q + 3'd1;
							state_q <= ecl_pkg::ST_DSC_NEXT;
						end else begin
							didx_q  <= didx_q + 5'd1;
							addr_q  <= addr_q + 9'd1;
							state_q <= ecl_pkg::ST_DSC_REQ;
						end
					end
				end
				ecl_pkg::ST_DONE: begin
					state_q <= ecl_pkg::ST_DONE;
				end
				default: begin
					state_q <= ecl_pkg::ST_DONE;
				end
			endcase
		end
	end

	// ==========================================================
	// completion and host gating
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			load_done  <= 1'b0;
			usb_accept <= 1'b0;
		end else begin
			load_done  <= state_q == ecl_pkg::ST_DONE;
			// [R21] host transactions refused while loading
			usb_accept <= state_q == ecl_pkg::ST_DONE;
		end
	end

	// ==========================================================
	// header field capture
	logic hdr_byte;
	assign hdr_byte = (state_q == ecl_pkg::ST_HDR_WAIT) && f.done;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			image_valid      <= 1'b0;
			mac_addr         <= ecl_pkg::RST_MAC;
			fs_poll_interval <= ecl_pkg::RST_FS_POLL;
			hs_poll_interval <= ecl_pkg::RST_HS_POLL;
			usb_lang_id      <= ecl_pkg::RST_LANG_ID;
			flags_q          <= 8'h00;
		end else if (hdr_byte) begin
			// [R1] signature check and station address
			if (addr_q == ecl_pkg::ADR_SIG)
				image_valid <= sig_ok;
			if (addr_q >= ecl_pkg::ADR_MAC_LO && addr_q <= ecl_pkg::ADR_MAC_HI)
				mac_addr[8 * (addr_q[2:0] - 3'd1) +: 8] <= f.data;
			// [R2] polling intervals
			if (addr_q == ecl_pkg::ADR_FS_POLL)
				fs_poll_interval <= f.data;
			if (addr_q == ecl_pkg::ADR_HS_POLL)
				hs_poll_interval <= f.data;
			if (addr_q == ecl_pkg::ADR_FLAGS)
				flags_q <= f.data;
			// [R3] language id halves
			if (addr_q == ecl_pkg::ADR_LANG_LO)
				usb_lang_id[7:0] <= f.data;
			if (addr_q == ecl_pkg::ADR_LANG_HI)
				usb_lang_id[15:8] <= f.data;
		end
	end

	// string and descriptor pairs: even address is length, odd is offset
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			str_len       <= '0;
			str_word_off  <= '0;
			desc_len      <= '0;
			desc_word_off <= '0;
		end else if (hdr_byte) begin
			// [R4] string pairs, length first
			if (addr_q >= ecl_pkg::ADR_STR_LO && addr_q <= ecl_pkg::ADR_STR_HI) begin
				if (!addr_q[0])
					str_len[3'((addr_q - ecl_pkg::ADR_STR_LO) >> 1)] <= f.data;
				else
					str_word_off[3'((addr_q - ecl_pkg::ADR_STR_LO) >> 1)] <= f.data;
			end
			// [R5] [R6] descriptor pairs, high-speed then full-speed
			if (addr_q >= ecl_pkg::ADR_DSC_LO && addr_q <= ecl_pkg::ADR_DSC_HI) begin
				if (!addr_q[0])
					desc_len[2'((addr_q - ecl_pkg::ADR_DSC_LO) >> 1)] <= f.data;
				else
					desc_word_off[2'((addr_q - ecl_pkg::ADR_DSC_LO) >> 1)] <= f.data;
			end
		end
	end

	// enhanced-only bytes; base variant's header walk never fetches them
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			gpio_wake_enable_bits <= ecl_pkg::RST_GPIO_WAKE;
			gpio_pme_flags        <= ecl_pkg::RST_PME_FLAGS;
		end else if (hdr_byte && ENHANCED) begin
			// [R7] eleven wake enable bits
			if (addr_q == ecl_pkg::ADR_WAKE_LO)
				gpio_wake_enable_bits[7:0] <= f.data;
			if (addr_q == ecl_pkg::ADR_WAKE_HI)
				gpio_wake_enable_bits[10:8] <= f.data[2:0];
			// [R8] wake-signalling flags byte
			if (addr_q == ecl_pkg::ADR_PME)
				gpio_pme_flags <= f.data;
		end
	end

	// ==========================================================
	// descriptor store
	always_ff @(posedge ref_clk) begin
		if (state_q == ecl_pkg::ST_DSC_WAIT && f.done)
			dmem[mem_index(slot_q[1:0], didx_q)] <= f.data;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			desc_present <= 4'h0;
		end else if (state_q == ecl_pkg::ST_DSC_WAIT && f.done && didx_q == dlast_q) begin
			desc_present[slot_q[1:0]] <= 1'b1;
		end
	end

	// read port, one cycle latency; empty slots read zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			desc_rd_data <= 8'h00;
		else if (!desc_present[desc_rd_sel] || desc_rd_idx >= ecl_pkg::DSC_MAX_BYTES)
			desc_rd_data <= 8'h00;
		else
			desc_rd_data <= desc_patch(desc_rd_sel, desc_rd_idx,
			                           dmem[mem_index(desc_rd_sel, desc_rd_idx)]);
	end

	// ==========================================================
	// power, wakeup and phy options
	logic [7:0] cfg_attr;
	logic       cfg_loaded;

	assign cfg_loaded = desc_present[ecl_pkg::SLOT_HS_CFG[1:0]] ||
	                    desc_present[ecl_pkg::SLOT_FS_CFG[1:0]];
	// the attribute byte is only read once loading is over, so the store is settled
	assign cfg_attr   = desc_present[ecl_pkg::SLOT_HS_CFG[1:0]] ?
	                    dmem[mem_index(ecl_pkg::SLOT_HS_CFG[1:0], ecl_pkg::CFG_IDX_ATTR)] :
	                    dmem[mem_index(ecl_pkg::SLOT_FS_CFG[1:0], ecl_pkg::CFG_IDX_ATTR)];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			remote_wakeup_en <= 1'b0;
			self_powered     <= 1'b0;
		end else if (load_done && cfg_loaded) begin
			// [R15] descriptor attributes win
			remote_wakeup_en <= cfg_attr[ecl_pkg::ATTR_WAKE_BIT];
			self_powered     <= cfg_attr[ecl_pkg::ATTR_SELF_BIT];
		end else if (load_done && image_valid) begin
			// [R14] [R16] [R17] flags byte over straps
			remote_wakeup_en <= flags_q[ecl_pkg::FLG_WAKEUP_BIT];
			self_powered     <= flags_q[ecl_pkg::FLG_POWER_BIT];
		end else begin
			remote_wakeup_en <= remote_wakeup_strap;
			self_powered     <= power_source_strap;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phy_output_boost    <= ecl_pkg::RST_BOOST;
			led_function_select <= 1'b0;
		end else if (ENHANCED && load_done && image_valid) begin
			// [R18] boost field
			phy_output_boost    <= flags_q[ecl_pkg::FLG_BOOST_LSB +: 2];
			// [R19] led select
			led_function_select <= flags_q[ecl_pkg::FLG_LED_BIT];
		end
	end

endmodule

// ### verification/ecl_eeprom_model.sv
// model: external configuration eeprom seen through the loader's byte read port
module ecl_eeprom_model (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       slow,
	input  wire logic       ee_rd_req,
	input  wire logic [8:0] ee_rd_addr,
	output logic            ee_rd_valid,
	output logic [7:0]      ee_rd_data
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] mem [0:511];
	logic       hit [0:511];
	int         rd_cnt;
	int         wait_cnt;

	// ==========================================================
	// answer path
	// data toggles outside the answer cycle so a late sample never sees a stale byte
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ee_rd_valid <= 1'b0;
			ee_rd_data  <= 8'h5a;
			wait_cnt    <= 0;
			rd_cnt      <= 0;
			foreach (hit[i]) hit[i] <= 1'b0;
		end else if (ee_rd_req && !ee_rd_valid && wait_cnt >= (slow ? 5 : 1)) begin
			ee_rd_valid     <= 1'b1;
			ee_rd_data      <= mem[ee_rd_addr];
			hit[ee_rd_addr] <= 1'b1;
			rd_cnt          <= rd_cnt + 1;
			wait_cnt        <= 0;
		end else begin
			ee_rd_valid <= 1'b0;
			ee_rd_data  <= ~ee_rd_data;
			wait_cnt    <= (ee_rd_req && !ee_rd_valid) ? wait_cnt + 1 : 0;
		end
	end
endmodule

// ### verification/ecl_loader_asserts.sv
// checker: read handshake, completion, strap fallback and descriptor patch properties
module ecl_loader_asserts (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       eeprom_size_strap,
	input wire logic       power_source_strap,
	input wire logic       ee_rd_req,
	input wire logic [8:0] ee_rd_addr,
	input wire logic       ee_rd_valid,
	input wire logic       load_done,
	input wire logic       usb_accept,
	input wire logic       self_powered,
	input wire logic [3:0] desc_present,
	input wire logic [1:0] desc_rd_sel,
	input wire logic [4:0] desc_rd_idx,
	input wire logic [7:0] desc_rd_data
);
	// ==========================================================
	// clocking and read steps
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence rd_taken;
		ee_rd_req && ee_rd_valid;
	endsequence

	sequence rd_gap;
		!ee_rd_req ##1 !ee_rd_req;
	endsequence

	// ==========================================================
	// properties
	req_hold_a: assert property (
		ee_rd_req && !ee_rd_valid |=> ee_rd_req && $stable(ee_rd_addr))
		else $error("read request moved before its answer");
	read_gap_a: assert property (rd_taken |=> rd_gap)
		else $error("read request not released after answer");
	addr_width_a: assert property (
		ee_rd_req && !eeprom_size_strap |-> ee_rd_addr[8:7] == 2'h0)
		else $error("small part addressed above seven bits");
	accept_gate_a: assert property (usb_accept == load_done)
		else $error("host acceptance differs from load completion");
	done_hold_a: assert property (load_done |=> load_done)
		else $error("load completion fell without reset");
	quiet_done_a: assert property (load_done |-> !ee_rd_req)
		else $error("eeprom read after load completion");
	strap_follow_a: assert property (
		!load_done && !$past(rst) |-> self_powered == $past(power_source_strap))
		else $error("power report does not follow strap during load");
	dev_len_a: assert property (
		load_done && desc_present[desc_rd_sel] && !desc_rd_sel[0] && desc_rd_idx == 5'h00
		|=> desc_rd_data == 8'h12)
		else $error("device descriptor length not patched");
	type_patch_a: assert property (
		load_done && desc_present[desc_rd_sel] && desc_rd_idx == 5'h01
		|=> desc_rd_data == ($past(desc_rd_sel[0]) ? 8'h02 : 8'h01))
		else $error("descriptor type not patched");
	absent_zero_a: assert property (
		load_done && (!desc_present[desc_rd_sel] || desc_rd_idx > 5'h11)
		|=> desc_rd_data == 8'h00)
		else $error("absent descriptor byte not zero");
endmodule

bind ecl_image_loader ecl_loader_asserts chk_u (
	.ref_clk, .rst, .eeprom_size_strap, .power_source_strap, .ee_rd_req, .ee_rd_addr,
	.ee_rd_valid, .load_done, .usb_accept, .self_powered, .desc_present, .desc_rd_sel,
	.desc_rd_idx, .desc_rd_data
);

// ### verification/tb_top.sv
// testbench: loads several eeprom images and checks every loaded field
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic             ref_clk, rst, slow, eeprom_size_strap, remote_wakeup_strap, power_source_strap;
	logic             ee_rd_req, ee_rd_valid, load_done, usb_accept, image_valid;
	logic             led_function_select, remote_wakeup_en, self_powered;
	logic [8:0]       ee_rd_addr;
	logic [7:0]       ee_rd_data, fs_poll_interval, hs_poll_interval, gpio_pme_flags, desc_rd_data;
	logic [47:0]      mac_addr;
	logic [15:0]      usb_lang_id;
	logic [4:0][7:0]  str_len, str_word_off;
	logic [3:0][7:0]  desc_len, desc_word_off;
	logic [3:0]       desc_present;
	logic [10:0]      gpio_wake_enable_bits;
	logic [1:0]       phy_output_boost, desc_rd_sel;
	logic [4:0]       desc_rd_idx;
	int               err_total, num_checks;

	ecl_image_loader #(.ENHANCED(1'b1)) dut_u (
		.ref_clk, .rst, .eeprom_size_strap, .remote_wakeup_strap, .power_source_strap,
		.ee_rd_req, .ee_rd_addr, .ee_rd_valid, .ee_rd_data, .load_done, .usb_accept,
		.image_valid, .mac_addr, .fs_poll_interval, .hs_poll_interval, .usb_lang_id, .str_len,
		.str_word_off, .desc_len, .desc_word_off, .desc_present, .gpio_wake_enable_bits,
		.gpio_pme_flags, .phy_output_boost, .led_function_select, .remote_wakeup_en,
		.self_powered, .desc_rd_sel, .desc_rd_idx, .desc_rd_data
	);

	ecl_eeprom_model ee_u (
		.ref_clk, .rst, .slow, .ee_rd_req, .ee_rd_addr, .ee_rd_valid, .ee_rd_data
	);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// shared tasks
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// stored length/type bytes are deliberately wrong so the patches are visible
	task automatic image(input logic [7:0] sig, input logic [7:0] fl, input logic dsc);
		logic [7:0] dtab [8];
		dtab = '{8'h12, 8'h20, 8'h12, 8'h30, 8'h00, 8'h44, 8'h12, 8'h90};
		for (int i = 0; i < 512; i++) ee_u.mem[i] = 8'(i) ^ 8'h3c;
		ee_u.mem[0] = sig;
		for (int i = 1; i < 7; i++) ee_u.mem[i] = 8'(8'h11 * i);
		ee_u.mem[9] = fl;
		for (int i = 0; i < 8; i++) ee_u.mem[22 + i] = (dsc || i % 2 == 1) ? dtab[i] : 8'h00;
		ee_u.mem[9'h040] = 8'h00;
		ee_u.mem[9'h041] = 8'h07;
		ee_u.mem[9'h061] = 8'h07;
		ee_u.mem[9'h121] = 8'h05;
		ee_u.mem[9'h067] = 8'h40;
		ee_u.mem[9'h127] = 8'h20;
		ee_u.mem[9'h042] = 8'h00;
		ee_u.mem[9'h043] = 8'h02;
		ee_u.mem[9'h047] = 8'h40;
		ee_u.mem[9'h051] = 8'h01;
	endtask

	task automatic boot(input logic sz, input logic wk, input logic pw, input logic sl);
		int n;
		@(posedge ref_clk);
		#1;
		rst = 1'b1;
		eeprom_size_strap = sz;
		remote_wakeup_strap = wk;
		power_source_strap = pw;
		slow = sl;
		repeat (3) @(posedge ref_clk);
		#1 rst = 1'b0;
		n = 0;
		while (load_done !== 1'b1 && n < 5000) begin
			@(posedge ref_clk);
			#1 n++;
		end
		if (load_done !== 1'b1) begin
			err_total++;
			$display("mismatch load_done expected 1 seen %b", load_done);
			finish_test();
		end else begin
			// power, wakeup and phy options are applied one edge after completion
			@(posedge ref_clk);
			#1;
		end
	endtask

	function automatic int hits(input int lo, input int hi);
		int n;
		n = 0;
		for (int a = lo; a <= hi; a++) n += ee_u.hit[a];
		return n;
	endfunction

	function automatic logic [7:0] exp_desc(input int s, input int i);
		logic [7:0] len;
		logic [7:0] off;
		len = ee_u.mem[22 + 2 * s];
		off = ee_u.mem[23 + 2 * s];
		if (len == 8'h00 || i > 17) return 8'h00;
		if (i == 0 && s % 2 == 0) return 8'h12;
		if (i == 1) return (s % 2 == 1) ? 8'h02 : 8'h01;
		return ee_u.mem[{off, 1'b0} + i];
	endfunction

	task automatic chk_image(input logic [7:0] fl, input logic dsc);
		chk("image_valid", image_valid, 1'b1);
		chk("mac_addr", mac_addr, 48'h665544332211);
		chk("fs_poll", fs_poll_interval, ee_u.mem[7]);
		chk("hs_poll", hs_poll_interval, ee_u.mem[8]);
		chk("lang_id", usb_lang_id, {ee_u.mem[11], ee_u.mem[10]});
		for (int k = 0; k < 5; k++) begin
			chk("str_len", str_len[k], ee_u.mem[12 + 2 * k]);
			chk("str_off", str_word_off[k], ee_u.mem[13 + 2 * k]);
		end
		for (int s = 0; s < 4; s++) begin
			chk("desc_len", desc_len[s], ee_u.mem[22 + 2 * s]);
			chk("desc_off", desc_word_off[s], ee_u.mem[23 + 2 * s]);
			chk("desc_present", desc_present[s], ee_u.mem[22 + 2 * s] != 8'h00);
		end
		chk("gpio_wake", gpio_wake_enable_bits, {ee_u.mem[31][2:0], ee_u.mem[30]});
		chk("pme_flags", gpio_pme_flags, ee_u.mem[32]);
		chk("boost", phy_output_boost, fl[5:4]);
		chk("led_function_select", led_function_select, fl[1]);
		chk("self_powered", self_powered, dsc ? 1'b1 : fl[0]);
		chk("remote_wakeup", remote_wakeup_en, dsc ? 1'b0 : fl[2]);
		chk("reads past image", hits(33, 63), 0);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		err_total = 0;
		num_checks = 0;
		rst = 1'b1;
		slow = 1'b0;
		eeprom_size_strap = 1'b1;
		remote_wakeup_strap = 1'b0;
		power_source_strap = 1'b0;
		desc_rd_sel = 2'h0;
		desc_rd_idx = 5'h00;
		// full image on the large part: config attributes beat flags and straps
		image(8'ha5, 8'h26, 1'b1);
		boot(1'b1, 1'b1, 1'b0, 1'b0);
		chk_image(8'h26, 1'b1);
		chk("zero length slot read", ee_u.hit[9'h088], 1'b0);
		for (int s = 0; s < 4; s++) begin
			for (int i = 0; i < 19; i++) begin
				desc_rd_sel = 2'(s);
				desc_rd_idx = 5'(i);
				@(posedge ref_clk);
				#1 chk("desc_rd_data", desc_rd_data, exp_desc(s, i));
			end
		end
		// flags only, small part, slow and prompt answers
		image(8'ha5, 8'h11, 1'b0);
		boot(1'b0, 1'b1, 1'b0, 1'b1);
		chk_image(8'h11, 1'b0);
		image(8'ha5, 8'h24, 1'b0);
		boot(1'b0, 1'b0, 1'b1, 1'b0);
		chk_image(8'h24, 1'b0);
		// bad signature: defaults and straps stay in force
		image(8'h5b, 8'h25, 1'b1);
		boot(1'b0, 1'b1, 1'b1, 1'b1);
		chk("bad image_valid", image_valid, 1'b0);
		chk("bad read count", ee_u.rd_cnt, 1);
		chk("bad mac", mac_addr, ecl_pkg::RST_MAC);
		chk("bad fs_poll", fs_poll_interval, ecl_pkg::RST_FS_POLL);
		chk("bad hs_poll", hs_poll_interval, ecl_pkg::RST_HS_POLL);
		chk("bad lang_id", usb_lang_id, ecl_pkg::RST_LANG_ID);
		chk("bad desc_present", desc_present, 4'h0);
		chk("bad self_powered", self_powered, 1'b1);
		chk("bad remote_wakeup", remote_wakeup_en, 1'b1);
		chk("bad usb_accept", usb_accept, 1'b1);
		finish_test();
	end
endmodule
